/* File: cdgc_regs.vh */
`ifndef CDGC_REGS_VH
`define CDGC_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CDGC_OFF_STATUS   8'h04
`define CDGC_OFF_IRQCFG   8'h05
`define CDGC_OFF_CTRL     8'h16
`define CDGC_OFF_GLOBAL   8'h1e

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CDGC_BIT_SENSE2   7
`define CDGC_BIT_SENSE1   6
`define CDGC_BIT_SOFTIRQ  5
`define CDGC_BIT_WAKE_EN  4
`define CDGC_BIT_REMOVAL  1
`define CDGC_BIT_DETECT   3
`define CDGC_BIT_CLRSEL   2

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define CDGC_RST_BYTE     8'h00
`define CDGC_RST_BIT      1'b0
`define CDGC_ARM_CYCLES   2'h3
`define CDGC_ONE_BYTE     8'h01

`endif

/* File: cdgc_sync.v */
// ----------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module cdgc_sync #(
	parameter WIDTH = 4
) (
	input  wire             i_clk,
	input  wire             i_reset,
	input  wire [WIDTH-1:0] i_pin,
	output wire [WIDTH-1:0] o_level
);

	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;
	reg [WIDTH-1:0] level;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			// A new level is accepted only once the second and third stages agree.
			always @(posedge i_clk) begin
				stage1[g] <= i_pin[g];
				stage2[g] <= stage1[g];
				stage3[g] <= stage2[g];
				if (i_reset) begin
					level[g] <= 1'b0;
				end else if (stage2[g] == stage3[g]) begin
					level[g] <= stage3[g];
				end
			end
		end
	endgenerate

	assign o_level = level;

endmodule

/* File: cdgc_irq.v */
`include "cdgc_regs.vh"

// ----------------------------------------------------------------
// Sticky status bits with mask and level interrupt
// ----------------------------------------------------------------
module cdgc_irq (
	input  wire       i_clk,
	input  wire       i_reset,
	input  wire [7:0] i_event,
	input  wire [7:0] i_mask,
	input  wire       i_read_clear,
	input  wire       i_write_clear,
	input  wire [7:0] i_write_data,
	output wire [7:0] o_status,
	output wire       o_irq
);

	reg [7:0] status;
	reg       irq;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_flag
			// A set in the same cycle as a clear wins.
			always @(posedge i_clk) begin
				if (i_reset) begin
					status[g] <= `CDGC_RST_BIT;
				end else if (i_event[g]) begin
					status[g] <= 1'b1;
				end else if (i_read_clear || (i_write_clear && i_write_data[g])) begin
					status[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge i_clk) begin
		if (i_reset) begin
			irq <= `CDGC_RST_BIT;
		end else begin
			irq <= |(status & i_mask);
		end
	end

	assign o_status = status;
	assign o_irq    = irq;

endmodule

/* File: cdgc_top.v */
`include "cdgc_regs.vh"

module cdgc_top (
	input  wire       i_clk,
	input  wire       i_reset,
	input  wire       i_bus_reset_n,
	input  wire       i_pme_enable,
	input  wire       i_cd1_n,
	input  wire       i_cd2_n,
	input  wire       i_vs1_n,
	input  wire       i_vs2_n,
	input  wire [7:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	output reg  [7:0] o_rdata,
	output reg        o_irq,
	output reg        o_wake_out_n,
	output reg        o_legacy_reg_reset
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Only the control register lives in this block; the status and mask
	// registers are kept here as full bytes, and the global register as its one clear-select bit.
	function hit;
		input [7:0] addr;
		input [7:0] offset;
		begin
			hit = (addr == offset);
		end
	endfunction

	// A write strobe to one register with one chosen bit of the data set.
	function wr_one;
		input         wr;
		input [7:0]   addr;
		input [7:0]   offset;
		input [7:0]   data;
		input integer pos;
		begin
			wr_one = wr && hit(addr, offset) && data[pos];
		end
	endfunction

	wire wr_ctrl;
	wire wr_irqcfg;
	wire wr_global;
	wire wr_status;
	wire rd_status;

	assign wr_ctrl   = i_wr && hit(i_addr, `CDGC_OFF_CTRL);
	assign wr_irqcfg = i_wr && hit(i_addr, `CDGC_OFF_IRQCFG);
	assign wr_global = i_wr && hit(i_addr, `CDGC_OFF_GLOBAL);
	assign wr_status = i_wr && hit(i_addr, `CDGC_OFF_STATUS);
	assign rd_status = i_rd && hit(i_addr, `CDGC_OFF_STATUS);

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	// Both the wake output and the removal pulse act on these levels, so a
	// contact that bounces must be filtered before it reaches them.
	wire [3:0] pin_level;
	wire       cd1_level;
	wire       cd2_level;
	wire       sense1_level;
	wire       sense2_level;

	cdgc_sync #(
		.WIDTH (4)
	) u_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_pin   ({i_vs2_n, i_vs1_n, i_cd2_n, i_cd1_n}),
		.o_level (pin_level)
	);

	assign cd1_level    = pin_level[0];
	assign cd2_level    = pin_level[1];
	assign sense1_level = pin_level[2];
	assign sense2_level = pin_level[3];

	// ----------------------------------------------------------------
	// Change detection
	// ----------------------------------------------------------------
	// The filtered levels need a few cycles to settle after reset, so
	// edges are ignored until the arm counter has run out.
	// The two contacts mate and part one after the other, so each of them
	// counts as a change of its own, and removal is the moment both read open.
	reg  [1:0] arm_count;
	reg        armed;
	reg  [1:0] cd_prev;
	reg        absent_prev;
	wire       card_absent;
	wire       detect_change;
	wire       card_removed;

	always @(posedge i_clk) begin
		if (i_reset) begin
			arm_count <= 2'h0;
			armed     <= 1'b0;
		end else if (arm_count != `CDGC_ARM_CYCLES) begin
			arm_count <= arm_count + 2'h1;
			armed     <= 1'b0;
		end else begin
			armed     <= 1'b1;
		end
	end

	always @(posedge i_clk) begin
		if (i_reset) begin
			cd_prev     <= 2'h0;
			absent_prev <= 1'b0;
		end else begin
			cd_prev     <= {cd2_level, cd1_level};
			absent_prev <= card_absent;
		end
	end

	assign card_absent   = cd1_level && cd2_level;
	assign detect_change = armed && (cd_prev != {cd2_level, cd1_level});
	assign card_removed  = armed && card_absent && !absent_prev;

	// ----------------------------------------------------------------
	// Sticky control bits
	// ----------------------------------------------------------------
	// Bus reset only reaches these bits while power events are disabled,
	// so that a host which drops bus power keeps its wake setup and the
	// wake output holds until the detect flag is cleared or a global reset.
	wire sticky_clear;
	reg  detect_wake_enable;
	reg  removal_reg_reset;

	assign sticky_clear = i_reset || (!i_bus_reset_n && !i_pme_enable);

	always @(posedge i_clk) begin
		if (sticky_clear) begin
			detect_wake_enable <= `CDGC_RST_BIT;
			removal_reg_reset  <= `CDGC_RST_BIT;
		end else if (wr_ctrl) begin
			detect_wake_enable <= i_wdata[`CDGC_BIT_WAKE_EN];
			removal_reg_reset  <= i_wdata[`CDGC_BIT_REMOVAL];
		end
	end

	// ----------------------------------------------------------------
	// Neighbouring registers used by this block
	// ----------------------------------------------------------------
	// Only the detect enable and the clear-mode select are used here; the
	// mask byte is kept whole because it also gates the interrupt.
	reg [7:0] irq_config;
	reg       flag_clear_select;

	always @(posedge i_clk) begin
		if (i_reset) begin
			irq_config        <= `CDGC_RST_BYTE;
			flag_clear_select <= `CDGC_RST_BIT;
		end else begin
			if (wr_irqcfg) begin
				irq_config <= i_wdata;
			end
			if (wr_global) begin
				flag_clear_select <= i_wdata[`CDGC_BIT_CLRSEL];
			end
		end
	end

	wire detect_enable;

	assign detect_enable = irq_config[`CDGC_BIT_DETECT];

	// ----------------------------------------------------------------
	// Status flag clearing
	// ----------------------------------------------------------------
	wire read_clear;
	wire write_clear;
	wire detect_cleared;
	wire detect_write_clear;

	// A read clears the flags only in read-clear mode, and it still returns
	// the flags as they stood before the clear.
	assign read_clear     = rd_status && !flag_clear_select;
	assign write_clear    = wr_status && flag_clear_select;
	assign detect_write_clear = flag_clear_select && wr_one(i_wr, i_addr, `CDGC_OFF_STATUS, i_wdata, `CDGC_BIT_DETECT);
	assign detect_cleared = read_clear || detect_write_clear;

	// ----------------------------------------------------------------
	// Software detect request
	// ----------------------------------------------------------------
	// The request never reads back; it lives until the detect status
	// flag that it raised is cleared or a second request write retires it.
	// A second write of 1 while the request is pending only retires it;
	// the detect flag already records the first one.
	wire soft_write;
	wire soft_event;
	reg  soft_pending;

	assign soft_write = wr_one(i_wr, i_addr, `CDGC_OFF_CTRL, i_wdata, `CDGC_BIT_SOFTIRQ);
	assign soft_event = soft_write && detect_enable && !soft_pending;

	always @(posedge i_clk) begin
		if (i_reset) begin
			soft_pending <= `CDGC_RST_BIT;
		end else if (soft_event) begin
			soft_pending <= 1'b1;
		end else if (detect_write_clear) begin
			soft_pending <= 1'b0;
		end else if (read_clear || soft_write) begin
			soft_pending <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Status and interrupt
	// ----------------------------------------------------------------
	wire [7:0] event_vec;
	wire [7:0] status;
	wire       irq_level;

	assign event_vec = {4'h0, detect_change || soft_event, 3'h0};

	cdgc_irq u_irq (
		.i_clk         (i_clk),
		.i_reset       (i_reset),
		.i_event       (event_vec),
		.i_mask        (irq_config),
		.i_read_clear  (read_clear),
		.i_write_clear (write_clear),
		.i_write_data  (i_wdata),
		.o_status      (status),
		.o_irq         (irq_level)
	);

	// ----------------------------------------------------------------
	// Wake output
	// ----------------------------------------------------------------
	reg wake_low;
	reg next_wake_low;

	// Setting beats clearing, so a change that lands in the same cycle as
	// the software clear keeps the output low.
	always @* begin
		next_wake_low = wake_low;
		if (detect_change && detect_wake_enable) begin
			next_wake_low = 1'b1;
		end else if (detect_cleared) begin
			next_wake_low = 1'b0;
		end
	end

	always @(posedge i_clk) begin
		if (sticky_clear) begin
			wake_low <= `CDGC_RST_BIT;
		end else begin
			wake_low <= next_wake_low;
		end
	end

	// ----------------------------------------------------------------
	// Removal reset pulse
	// ----------------------------------------------------------------
	// The removal edge is one cycle wide, so the pulse is one cycle wide too.
	wire legacy_pulse;

	assign legacy_pulse = card_removed && removal_reg_reset;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Reserved positions and the write-only request stay zero on every read.
	reg [7:0] ctrl_view;
	reg [7:0] next_rdata;

	always @* begin
		ctrl_view                    = `CDGC_RST_BYTE;
		ctrl_view[`CDGC_BIT_SENSE2]  = sense2_level;
		ctrl_view[`CDGC_BIT_SENSE1]  = sense1_level;
		ctrl_view[`CDGC_BIT_SOFTIRQ] = 1'b0;
		ctrl_view[`CDGC_BIT_WAKE_EN] = detect_wake_enable;
		ctrl_view[`CDGC_BIT_REMOVAL] = removal_reg_reset;
	end

	always @* begin
		next_rdata = `CDGC_RST_BYTE;
		if (i_rd) begin
			case (i_addr)
			`CDGC_OFF_CTRL: begin
				next_rdata = ctrl_view;
			end
			`CDGC_OFF_STATUS: begin
				next_rdata = status;
			end
			`CDGC_OFF_IRQCFG: begin
				next_rdata = irq_config;
			end
			`CDGC_OFF_GLOBAL: begin
				next_rdata[`CDGC_BIT_CLRSEL] = flag_clear_select;
			end
			default: begin
				next_rdata = `CDGC_RST_BYTE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	// Every port leaves from a flip-flop, so the host never sees a glitch
	// from the address decode.
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_rdata            <= `CDGC_RST_BYTE;
			o_irq              <= `CDGC_RST_BIT;
			o_wake_out_n       <= 1'b1;
			o_legacy_reg_reset <= `CDGC_RST_BIT;
		end else begin
			o_rdata            <= next_rdata;
			o_irq              <= irq_level;
			o_wake_out_n       <= !wake_low;
			o_legacy_reg_reset <= legacy_pulse;
		end
	end

endmodule

/* File: cdgc_sva.sv */
module cdgc_sva (
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic       i_bus_reset_n,
	input wire logic       i_pme_enable,
	input wire logic       i_cd1_n,
	input wire logic       i_cd2_n,
	input wire logic       i_vs1_n,
	input wire logic       i_vs2_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       o_irq,
	input wire logic       o_wake_out_n,
	input wire logic       o_legacy_reg_reset
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cd_q;
	logic [1:0] vs_q;
	logic [3:0] since_cd;
	logic [3:0] since_vs;
	logic [3:0] since_evt;
	logic       armed;
	logic       acc;
	logic       evt;
	// ----------------------------------------------------------------
	// Cycle counters since the last pin change or raising event.
	// ----------------------------------------------------------------
	assign acc = ((i_wr || i_rd) && i_addr == 8'h04) || !i_bus_reset_n;
	assign evt = (cd_q != {i_cd2_n, i_cd1_n}) || (i_wr && i_addr == 8'h05) || (i_wr && i_addr == 8'h16 && i_wdata[5]);
	always_ff @(posedge i_clk) begin
		cd_q <= {i_cd2_n, i_cd1_n};
		vs_q <= {i_vs2_n, i_vs1_n};
		if (i_reset) begin
			since_cd <= 4'hf;
			since_vs <= 4'h0;
			since_evt <= 4'hf;
			armed <= 1'b0;
		end else begin
			since_cd <= (cd_q != {i_cd2_n, i_cd1_n}) ? 4'h0 : since_cd + {3'h0, since_cd != 4'hf};
			since_vs <= (vs_q != {i_vs2_n, i_vs1_n}) ? 4'h0 : since_vs + {3'h0, since_vs != 4'hf};
			since_evt <= evt ? 4'h0 : since_evt + {3'h0, since_evt != 4'hf};
			armed <= armed || (i_wr && i_addr == 8'h16 && i_wdata[4]);
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
	AST_SOFT_READ_ZERO: assert property (
		$past(i_rd) && $past(i_addr) == 8'h16 |-> !o_rdata[5]) else $error("soft request bit read nonzero");
	AST_RSVD_ZERO: assert property (
		$past(i_rd) && $past(i_addr) == 8'h16 |-> o_rdata[3:2] == 2'h0 && !o_rdata[0]) else $error("reserved bits nonzero");
	AST_SENSE_LEVEL: assert property (
		$past(i_rd) && $past(i_addr) == 8'h16 && since_vs > 4'h8 |-> o_rdata[7:6] == vs_q) else $error("sense level wrong");
	AST_WAKE_HOLD: assert property (
		!o_wake_out_n && !acc && !$past(acc) && !$past(acc, 2) && !$past(acc, 3) |=> !o_wake_out_n) else $error("wake released early");
	AST_WAKE_OFF: assert property (!armed |-> o_wake_out_n) else $error("wake while disabled");
	AST_WAKE_CAUSE: assert property ($fell(o_wake_out_n) |-> since_cd <= 4'hc) else $error("wake without detect change");
	AST_LEGACY_CAUSE: assert property (
		o_legacy_reg_reset |-> since_cd <= 4'hc && i_cd1_n && i_cd2_n) else $error("legacy reset without removal");
	AST_LEGACY_ONE: assert property (o_legacy_reg_reset |=> !o_legacy_reg_reset) else $error("legacy pulse too long");
	AST_IRQ_CAUSE: assert property ($rose(o_irq) |-> since_evt <= 4'hc) else $error("interrupt without event");
	COV_WAKE: cover property ($fell(o_wake_out_n));
	COV_LEGACY: cover property (o_legacy_reg_reset);
	COV_IRQ: cover property ($rose(o_irq));
endmodule

/* File: cdgc_card_model.sv */
// ----------------------------------------------------------------
// Card in the socket: detect contacts mate one after the other.
// ----------------------------------------------------------------
module cdgc_card_model (
	input  wire logic i_clk,
	input  wire logic i_present,
	input  wire logic i_vs1_n,
	input  wire logic i_vs2_n,
	output wire logic o_cd1_n,
	output wire logic o_cd2_n,
	output wire logic o_vs1_n,
	output wire logic o_vs2_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] seat = 3'h7;
	always @(posedge i_clk) begin
		seat <= {seat[1:0], i_present};
	end
	// Socket pull-ups take every pin high once the card is gone.
	assign o_cd1_n = ~seat[0];
	assign o_cd2_n = ~seat[2];
	assign o_vs1_n = seat[0] ? i_vs1_n : 1'b1;
	assign o_vs2_n = seat[0] ? i_vs2_n : 1'b1;
endmodule

/* File: card_detect_general_control_tb_top.sv */
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
	$display("unexpected at %0t: got %0h exp %0h", $time, got, exp); end end
module card_detect_general_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       i_clk = 0, i_reset = 1, i_bus_reset_n = 1, i_pme_enable = 0, i_wr = 0, i_rd = 0;
	logic [7:0] i_addr = 0, i_wdata = 0, o_rdata;
	logic       i_cd1_n, i_cd2_n, i_vs1_n, i_vs2_n, o_irq, o_wake_out_n, o_legacy_reg_reset;
	logic       present = 1, vs1 = 1, vs2 = 0;
	int         fail_count = 0, check_count = 0, cyc = 0, pulses = 0;
	always #5 i_clk = ~i_clk;
	cdgc_top u_cdgc_top (.i_clk(i_clk), .i_reset(i_reset), .i_bus_reset_n(i_bus_reset_n),
		.i_pme_enable(i_pme_enable), .i_cd1_n(i_cd1_n), .i_cd2_n(i_cd2_n), .i_vs1_n(i_vs1_n),
		.i_vs2_n(i_vs2_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_irq(o_irq), .o_wake_out_n(o_wake_out_n), .o_legacy_reg_reset(o_legacy_reg_reset));
	cdgc_card_model u_cdgc_card_model (.i_clk(i_clk), .i_present(present), .i_vs1_n(vs1), .i_vs2_n(vs2),
		.o_cd1_n(i_cd1_n), .o_cd2_n(i_cd2_n), .o_vs1_n(i_vs1_n), .o_vs2_n(i_vs2_n));
	always @(posedge i_clk) begin
		cyc++;
		if (o_legacy_reg_reset === 1'b1) pulses++;
		if (cyc == 3000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk) begin i_wr <= 1; i_addr <= a; i_wdata <= d; end
		@(posedge i_clk) i_wr <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk) begin i_rd <= 1; i_addr <= a; end
		@(posedge i_clk) i_rd <= 0;
		#1 `CHK(o_rdata, e)
	endtask
	task automatic bus_reset(input logic pme);
		@(posedge i_clk) begin i_pme_enable <= pme; i_bus_reset_n <= 0; end
		@(posedge i_clk) i_bus_reset_n <= 1;
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_reset <= 0;
		repeat (12) @(posedge i_clk);
		rd(8'h16, 8'h40);
		rd(8'h33, 8'h00);
		vs1 <= 0;
		vs2 <= 1;
		repeat (12) @(posedge i_clk);
		rd(8'h16, 8'h80);
		wr(8'h16, 8'h2d);
		rd(8'h16, 8'h80);
		rd(8'h04, 8'h00);
		wr(8'h05, 8'h08);
		rd(8'h05, 8'h08);
		repeat (3) @(posedge i_clk);
		rd(8'h04, 8'h00);
		wr(8'h16, 8'h20);
		repeat (3) @(posedge i_clk);
		`CHK(o_irq, 1'b1)
		rd(8'h04, 8'h08);
		rd(8'h04, 8'h00);
		repeat (3) @(posedge i_clk);
		`CHK(o_irq, 1'b0)
		wr(8'h1e, 8'h04);
		rd(8'h1e, 8'h04);
		wr(8'h16, 8'h20);
		repeat (3) @(posedge i_clk);
		rd(8'h04, 8'h08);
		wr(8'h04, 8'h08);
		repeat (3) @(posedge i_clk);
		rd(8'h04, 8'h00);
		wr(8'h16, 8'h20);
		rd(8'h04, 8'h08);
		wr(8'h04, 8'h08);
		wr(8'h16, 8'h12);
		rd(8'h16, 8'h92);
		present <= 0;
		repeat (16) @(posedge i_clk);
		`CHK(o_wake_out_n, 1'b0)
		`CHK(pulses, 1)
		repeat (20) @(posedge i_clk);
		`CHK(o_wake_out_n, 1'b0)
		wr(8'h04, 8'h08);
		repeat (3) @(posedge i_clk);
		`CHK(o_wake_out_n, 1'b1)
		present <= 1;
		repeat (16) @(posedge i_clk);
		`CHK(pulses, 1)
		wr(8'h04, 8'h08);
		bus_reset(1);
		rd(8'h16, 8'h92);
		bus_reset(0);
		rd(8'h16, 8'h80);
		present <= 0;
		repeat (16) @(posedge i_clk);
		`CHK(o_wake_out_n, 1'b1)
		`CHK(pulses, 1)
		wr(8'h16, 8'h12);
		@(posedge i_clk) begin i_pme_enable <= 1; i_reset <= 1; end
		@(posedge i_clk) i_reset <= 0;
		rd(8'h16, 8'hc0);
		finish_test();
	end
endmodule
bind cdgc_top cdgc_sva u_cdgc_sva (.i_clk(i_clk), .i_reset(i_reset), .i_bus_reset_n(i_bus_reset_n),
	.i_pme_enable(i_pme_enable), .i_cd1_n(i_cd1_n), .i_cd2_n(i_cd2_n), .i_vs1_n(i_vs1_n), .i_vs2_n(i_vs2_n),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
	.o_wake_out_n(o_wake_out_n), .o_legacy_reg_reset(o_legacy_reg_reset));
